//--- verilog/mfls_regs.svh
// register offsets, fields, reset values and widths of the light switch
//
// Summary of operation
// - a rising edge on the push input switches the output on.
// - push held for hold_span from off enters permanent light, no off delay.
// - push released before hold_span starts off-delay timing of off_delay_span.
// - during off delay the output clears when elapsed_clock equals off_delay_span.
// - optional pre-warning drops output for warning_length, warning_lead before the end.
// - another push while output active clears the timer and the output.
// - the clear input zeroes elapsed_clock and forces the output low, above all.
// - without retention, power return clears output and elapsed time.
// - with retention, output and elapsed time survive power loss.
// - each of the four times is a constant or a live outside value.
`ifndef MFLS_REGS_SVH
`define MFLS_REGS_SVH
`define MFLS_AW           4
`define MFLS_TW           16
`define MFLS_OFS_CTRL     4'h0
`define MFLS_OFS_OFF      4'h1
`define MFLS_OFS_HOLD     4'h2
`define MFLS_OFS_LEAD     4'h3
`define MFLS_OFS_LEN      4'h4
`define MFLS_OFS_STAT     4'h5
`define MFLS_OFS_ELAP     4'h6
`define MFLS_CTRL_WARN    0
`define MFLS_CTRL_RET     1
`define MFLS_CTRL_SRC_LO  4
`define MFLS_CTRL_W       8
`define MFLS_CTRL_RST     8'h00
`define MFLS_OFF_RST      16'h000A
`define MFLS_HOLD_RST     16'h0005
`define MFLS_LEAD_RST     16'h0003
`define MFLS_LEN_RST      16'h0001
`endif

//--- verilog/mfls_pkg.sv
// types shared by the light switch
package mfls_pkg;
  typedef enum logic [1:0] {
    MFLS_IDLE,
    MFLS_HOLD,
    MFLS_PERM,
    MFLS_DELAY
  } mfls_state_e;
  typedef logic [15:0] mfls_time_t;
endpackage

//--- verilog/mfls_top.sv
// multi-function light switch: pulse switch with off delay and permanent light
`timescale 1ns/1ps
`include "mfls_regs.svh"
module mfls_top (
  // clock and reset
  input  wire logic                clk_sys_i,
  input  wire logic                rst_i,
  // avalon-mm slave, word addressed
  input  wire logic [`MFLS_AW-1:0] avs_address_i,
  input  wire logic                avs_read_i,
  input  wire logic                avs_write_i,
  input  wire logic [31:0]         avs_writedata_i,
  input  wire logic [3:0]          avs_byteenable_i,
  output logic      [31:0]         avs_readdata_o,
  output logic                     avs_waitrequest_o,
  // switch inputs and time base
  input  wire logic                push_i,
  input  wire logic                clear_i,
  input  wire logic                tick_i,
  input  wire logic                scan_i,
  input  wire logic                power_up_i,
  // live values from other blocks
  input  wire logic [`MFLS_TW-1:0] live_off_i,
  input  wire logic [`MFLS_TW-1:0] live_hold_i,
  input  wire logic [`MFLS_TW-1:0] live_lead_i,
  input  wire logic [`MFLS_TW-1:0] live_len_i,
  // switched output
  output logic                     switch_output_o
);

  // byte-lane merge, used for every writable register
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    be_merge = (old_v & ~m) | (new_v & m);
  endfunction

  // constant or live value, chosen per time parameter
  function automatic mfls_pkg::mfls_time_t pick(input logic sel,
                                                input mfls_pkg::mfls_time_t k,
                                                input mfls_pkg::mfls_time_t v);
    pick = sel ? v : k;
  endfunction

  // registers
  logic [`MFLS_CTRL_W-1:0] ctrl_r;
  mfls_pkg::mfls_time_t    off_k_r;
  mfls_pkg::mfls_time_t    hold_k_r;
  mfls_pkg::mfls_time_t    lead_k_r;
  mfls_pkg::mfls_time_t    len_k_r;
  logic                    ack_r;
  logic [31:0]             rdata_r;

  // switch state
  mfls_pkg::mfls_state_e   state_r;
  mfls_pkg::mfls_state_e   state_nxt;
  mfls_pkg::mfls_time_t    elapsed_clock_r;
  mfls_pkg::mfls_time_t    elapsed_clock_nxt;
  mfls_pkg::mfls_time_t    hold_cnt_r;
  mfls_pkg::mfls_time_t    hold_cnt_nxt;
  logic                    push_prev_r;
  logic                    out_r;
  logic                    out_nxt;

  // bus decode
  wire logic       bus_req   = avs_read_i | avs_write_i;
  wire logic       wr_go     = avs_write_i & ack_r;
  wire logic       sel_ctrl  = (avs_address_i == `MFLS_OFS_CTRL);
  wire logic       sel_off   = (avs_address_i == `MFLS_OFS_OFF);
  wire logic       sel_hold  = (avs_address_i == `MFLS_OFS_HOLD);
  wire logic       sel_lead  = (avs_address_i == `MFLS_OFS_LEAD);
  wire logic       sel_len   = (avs_address_i == `MFLS_OFS_LEN);
  wire logic       sel_stat  = (avs_address_i == `MFLS_OFS_STAT);
  wire logic       sel_elap  = (avs_address_i == `MFLS_OFS_ELAP);
  wire logic [31:0] wmerge_ctrl = be_merge({24'h000000, ctrl_r}, avs_writedata_i,
                                           avs_byteenable_i);
  wire logic [31:0] wmerge_off  = be_merge({16'h0000, off_k_r}, avs_writedata_i,
                                           avs_byteenable_i);
  wire logic [31:0] wmerge_hold = be_merge({16'h0000, hold_k_r}, avs_writedata_i,
                                           avs_byteenable_i);
  wire logic [31:0] wmerge_lead = be_merge({16'h0000, lead_k_r}, avs_writedata_i,
                                           avs_byteenable_i);
  wire logic [31:0] wmerge_len  = be_merge({16'h0000, len_k_r}, avs_writedata_i,
                                           avs_byteenable_i);

  // read mux; unmapped words read zero
  logic [31:0] rmux;
  always_comb begin
    if (sel_ctrl) begin
      rmux = {24'h000000, ctrl_r};
    end else if (sel_off) begin
      rmux = {16'h0000, off_k_r};
    end else if (sel_hold) begin
      rmux = {16'h0000, hold_k_r};
    end else if (sel_lead) begin
      rmux = {16'h0000, lead_k_r};
    end else if (sel_len) begin
      rmux = {16'h0000, len_k_r};
    end else if (sel_stat) begin
      rmux = {28'h0000000, state_r, push_prev_r, out_r};
    end else if (sel_elap) begin
      rmux = {16'h0000, elapsed_clock_r};
    end else begin
      rmux = 32'h00000000;
    end
  end

  // one wait state per access, so read data is always registered
  assign avs_waitrequest_o = bus_req & ~ack_r;
  assign avs_readdata_o    = rdata_r;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h00000000;
    end else begin
      ack_r   <= bus_req & ~ack_r;
      rdata_r <= rmux;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ctrl_r   <= `MFLS_CTRL_RST;
      off_k_r  <= `MFLS_OFF_RST;
      hold_k_r <= `MFLS_HOLD_RST;
      lead_k_r <= `MFLS_LEAD_RST;
      len_k_r  <= `MFLS_LEN_RST;
    end else if (wr_go) begin
      if (sel_ctrl) ctrl_r <= wmerge_ctrl[`MFLS_CTRL_W-1:0];
      if (sel_off)  off_k_r  <= wmerge_off[15:0];
      if (sel_hold) hold_k_r <= wmerge_hold[15:0];
      if (sel_lead) lead_k_r <= wmerge_lead[15:0];
      if (sel_len)  len_k_r  <= wmerge_len[15:0];
    end
  end

  // effective times; live values are taken each cycle, no latching
  wire logic [3:0] src = ctrl_r[`MFLS_CTRL_SRC_LO+3:`MFLS_CTRL_SRC_LO];
  wire mfls_pkg::mfls_time_t off_delay_span = pick(src[0], off_k_r,  live_off_i);
  wire mfls_pkg::mfls_time_t hold_span      = pick(src[1], hold_k_r, live_hold_i);
  wire mfls_pkg::mfls_time_t warning_lead   = pick(src[2], lead_k_r, live_lead_i);
  wire mfls_pkg::mfls_time_t warning_length = pick(src[3], len_k_r,  live_len_i);
  wire logic warn_en = ctrl_r[`MFLS_CTRL_WARN];
  wire logic retain  = ctrl_r[`MFLS_CTRL_RET];

  // comparisons; a lead longer than the delay warns from the start
  wire logic push_rise = scan_i & push_i & ~push_prev_r;
  wire logic push_fall = scan_i & ~push_i;
  wire logic hold_done = scan_i & (hold_cnt_r >= hold_span);
  wire logic off_done  = scan_i & (elapsed_clock_r == off_delay_span);
  wire logic [16:0] warn_from = (warning_lead > off_delay_span) ? 17'h00000 :
                                {1'b0, off_delay_span} - {1'b0, warning_lead};
  wire logic [16:0] warn_to   = warn_from + {1'b0, warning_length};
  wire logic in_warn   = warn_en & (state_r == mfls_pkg::MFLS_DELAY) &
                         ({1'b0, elapsed_clock_r} >= warn_from) &
                         ({1'b0, elapsed_clock_r} <  warn_to);
  wire logic lost_state = power_up_i & ~retain;

  // next state; the clear input and power return take priority
  always_comb begin
    state_nxt         = state_r;
    elapsed_clock_nxt = elapsed_clock_r;
    hold_cnt_nxt      = hold_cnt_r;
    out_nxt           = out_r;
    if (clear_i) begin
      state_nxt         = mfls_pkg::MFLS_IDLE;
      elapsed_clock_nxt = 16'h0000;
      hold_cnt_nxt      = 16'h0000;
      out_nxt           = 1'b0;
    end else if (lost_state) begin
      state_nxt         = mfls_pkg::MFLS_IDLE;
      elapsed_clock_nxt = 16'h0000;
      hold_cnt_nxt      = 16'h0000;
      out_nxt           = 1'b0;
    end else if (power_up_i) begin
      state_nxt = state_r;
    end else if (push_rise && state_r != mfls_pkg::MFLS_IDLE) begin
      state_nxt         = mfls_pkg::MFLS_IDLE;
      elapsed_clock_nxt = 16'h0000;
      hold_cnt_nxt      = 16'h0000;
      out_nxt           = 1'b0;
    end else begin
      case (state_r)
        mfls_pkg::MFLS_IDLE: begin
          if (push_rise) begin
            state_nxt    = mfls_pkg::MFLS_HOLD;
            hold_cnt_nxt = 16'h0000;
            out_nxt      = 1'b1;
          end
        end
        mfls_pkg::MFLS_HOLD: begin
          if (push_fall) begin
            state_nxt         = mfls_pkg::MFLS_DELAY;
            elapsed_clock_nxt = 16'h0000;
          end else if (hold_done) begin
            state_nxt = mfls_pkg::MFLS_PERM;
            out_nxt   = 1'b1;
          end else if (tick_i) begin
            hold_cnt_nxt = hold_cnt_r + 16'h0001;
          end
        end
        mfls_pkg::MFLS_PERM: begin
          out_nxt = 1'b1;
        end
        mfls_pkg::MFLS_DELAY: begin
          if (off_done) begin
            state_nxt = mfls_pkg::MFLS_IDLE;
            out_nxt   = 1'b0;
          end else begin
            out_nxt = ~in_warn;
            if (tick_i && elapsed_clock_r != off_delay_span) begin
              elapsed_clock_nxt = elapsed_clock_r + 16'h0001;
            end
          end
        end
        default: begin
          state_nxt = mfls_pkg::MFLS_IDLE;
          out_nxt   = 1'b0;
        end
      endcase
    end
  end

  // edge memory moves only on scans, so a pulse between scans is not seen
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      push_prev_r <= 1'b0;
    end else if (scan_i) begin
      // tracked through clear too, so a release during clear is not lost
      push_prev_r <= push_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_r         <= mfls_pkg::MFLS_IDLE;
      elapsed_clock_r <= 16'h0000;
      hold_cnt_r      <= 16'h0000;
      out_r           <= 1'b0;
    end else begin
      state_r         <= state_nxt;
      elapsed_clock_r <= elapsed_clock_nxt;
      hold_cnt_r      <= hold_cnt_nxt;
      out_r           <= out_nxt;
    end
  end

  assign switch_output_o = out_r;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  rise_sets_out_a: assert property (
    state_r == mfls_pkg::MFLS_IDLE && push_rise && !clear_i && !power_up_i
    |=> switch_output_o && state_r == mfls_pkg::MFLS_HOLD)
    else $error("rising push did not switch on");

  hold_to_perm_a: assert property (
    state_r == mfls_pkg::MFLS_HOLD && hold_done && !push_fall && !clear_i
    && !power_up_i && !push_rise
    |=> state_r == mfls_pkg::MFLS_PERM && switch_output_o)
    else $error("hold span did not give permanent light");

  perm_stays_a: assert property (
    state_r == mfls_pkg::MFLS_PERM && !push_rise && !clear_i && !lost_state
    |=> state_r == mfls_pkg::MFLS_PERM && switch_output_o)
    else $error("permanent light dropped");

  early_release_a: assert property (
    state_r == mfls_pkg::MFLS_HOLD && push_fall && !clear_i && !power_up_i
    |=> state_r == mfls_pkg::MFLS_DELAY && elapsed_clock_r == 16'h0000)
    else $error("early release did not start off delay");

  off_expiry_a: assert property (
    state_r == mfls_pkg::MFLS_DELAY && off_done && !clear_i && !power_up_i
    && !push_rise
    |=> !switch_output_o && state_r == mfls_pkg::MFLS_IDLE)
    else $error("off delay end did not clear output");

  warn_drop_a: assert property (
    state_r == mfls_pkg::MFLS_DELAY && !off_done && !clear_i && !power_up_i
    && !push_rise
    |=> switch_output_o == !$past(in_warn))
    else $error("pre-warning window wrong");

  retrig_clear_a: assert property (
    state_r != mfls_pkg::MFLS_IDLE && push_rise && !clear_i && !power_up_i
    |=> !switch_output_o && elapsed_clock_r == 16'h0000 && hold_cnt_r == 16'h0000)
    else $error("second push did not clear");

  clear_wins_a: assert property (
    clear_i |=> !switch_output_o && elapsed_clock_r == 16'h0000)
    else $error("clear input did not win");

  power_lost_a: assert property (
    lost_state && !clear_i |=> !switch_output_o && elapsed_clock_r == 16'h0000)
    else $error("state kept without retention");

  power_kept_a: assert property (
    power_up_i && retain && !clear_i
    |=> $stable(switch_output_o) && $stable(elapsed_clock_r))
    else $error("retained state lost");

  tick_count_a: assert property (
    state_r == mfls_pkg::MFLS_DELAY && tick_i && !off_done && !clear_i
    && !power_up_i && !push_rise && elapsed_clock_r != off_delay_span
    |=> elapsed_clock_r == $past(elapsed_clock_r) + 16'h0001)
    else $error("elapsed clock did not advance");

  idle_dark_a: assert property (
    state_r == mfls_pkg::MFLS_IDLE |-> !switch_output_o)
    else $error("output on while idle");

  lit_active_a: assert property (
    (state_r == mfls_pkg::MFLS_HOLD || state_r == mfls_pkg::MFLS_PERM) |-> switch_output_o)
    else $error("output off while held or permanent");

  hold_tick_a: assert property (
    state_r == mfls_pkg::MFLS_HOLD && tick_i && !push_fall && !hold_done && !push_rise
    && !clear_i && !power_up_i |=> hold_cnt_r == $past(hold_cnt_r) + 16'h0001)
    else $error("hold count did not advance");

  delay_still_a: assert property (
    state_r == mfls_pkg::MFLS_DELAY && !tick_i && !clear_i && !lost_state && !push_rise
    |=> elapsed_clock_r == $past(elapsed_clock_r))
    else $error("elapsed clock moved without tick");

  power_state_a: assert property (
    power_up_i && retain && !clear_i
    |=> state_r == $past(state_r))
    else $error("retained mode lost");

  clear_idle_a: assert property (
    clear_i |=> state_r == mfls_pkg::MFLS_IDLE && hold_cnt_r == 16'h0000)
    else $error("clear input left state running");

  lost_idle_a: assert property (
    lost_state && !clear_i |=> state_r == mfls_pkg::MFLS_IDLE)
    else $error("mode kept without retention");

  warn_off_a: assert property (
    !warn_en && state_r == mfls_pkg::MFLS_DELAY && !off_done && !clear_i && !power_up_i
    && !push_rise |=> switch_output_o)
    else $error("output dropped with warning disabled");

endmodule

//--- verification/mfls_ctrl_model.sv
// controller model: scan cycle and time-base pulses for the light switch
`timescale 1ns/1ps
module mfls_ctrl_model (
  // clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  // scan and time-base pulses
  output logic      scan_o,
  output logic      tick_o
);
  logic [2:0] phase_r;
  logic [2:0] phase_nxt;
  assign phase_nxt = phase_r + 3'h1;
  // scan every other cycle, one tick per four scans; all times share this base
  // ticks land on scan cycles so a tick is never lost between compares
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      phase_r <= 3'h0;
      scan_o  <= 1'b0;
      tick_o  <= 1'b0;
    end else begin
      phase_r <= phase_nxt;
      scan_o  <= phase_nxt[0];
      tick_o  <= (phase_nxt == 3'h7);
    end
  end
endmodule

//--- verification/tb.sv
// self-checking bench for the light switch
`timescale 1ns/1ps
`include "mfls_regs.svh"
module tb;
  logic        clk_sys_i = 1'b0;
  logic        rst_i     = 1'b1;
  logic [3:0]  adr       = 4'h0;
  logic        rd        = 1'b0;
  logic        wr        = 1'b0;
  logic [31:0] wdat      = 32'h0;
  logic [3:0]  be        = 4'hF;
  logic [31:0] rdat;
  logic        wreq;
  logic        push      = 1'b0;
  logic        clr       = 1'b0;
  logic        pwr       = 1'b0;
  logic        scan;
  logic        tick;
  logic        q;
  logic [15:0] l_off     = 16'h0;
  logic [15:0] l_hold    = 16'h0;
  logic [15:0] l_lead    = 16'h0;
  logic [15:0] l_len     = 16'h0;
  int          n_errors  = 0;
  int          total_checks = 0;

  always #2.5 clk_sys_i = ~clk_sys_i;

  mfls_ctrl_model i_mfls_ctrl_model (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .scan_o(scan), .tick_o(tick)
  );

  mfls_top i_mfls_top (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(be),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .push_i(push), .clear_i(clr),
    .tick_i(tick), .scan_i(scan), .power_up_i(pwr), .live_off_i(l_off),
    .live_hold_i(l_hold), .live_lead_i(l_lead), .live_len_i(l_len),
    .switch_output_o(q)
  );

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // request held until the edge where waitrequest is seen low
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    logic ws;
    @(posedge clk_sys_i);
    adr  <= a;
    wdat <= d;
    wr   <= w;
    rd   <= ~w;
    do begin
      @(posedge clk_sys_i);
      ws = wreq;
      r  = rdat;
    end while (ws !== 1'b0);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic wrt(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] r;
    acc(1'b1, a, d, r);
  endtask

  task automatic chk_rd(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] r;
    acc(1'b0, a, 32'h0, r);
    total_checks++;
    if (r !== e) begin
      n_errors++;
      $display("wrong value at %0t: reg %0h read %0h want %0h", $time, a, r, e);
    end
  endtask

  task automatic chk_q(input logic e);
    @(negedge clk_sys_i);
    total_checks++;
    if (q !== e) begin
      n_errors++;
      $display("wrong value at %0t: output %b want %b", $time, q, e);
    end
  endtask

  // push is a level; it must span at least one scan to be seen
  task automatic pulse(input int n);
    @(posedge clk_sys_i);
    push <= 1'b1;
    repeat (n) @(posedge clk_sys_i);
    push <= 1'b0;
    repeat (8) @(posedge clk_sys_i);
  endtask

  task automatic wait_q(input logic v);
    int i;
    i = 0;
    while (q !== v && i < 400) begin
      @(negedge clk_sys_i);
      i++;
    end
    chk_q(v);
  endtask

  task automatic power();
    @(posedge clk_sys_i);
    pwr <= 1'b1;
    @(posedge clk_sys_i);
    pwr <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
  endtask

  initial begin
    #100000;
    n_errors++;
    $display("wrong value at %0t: watchdog expired", $time);
    final_report();
  end

  initial begin
    repeat (8) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    chk_rd(4'h0, {24'h0, `MFLS_CTRL_RST});
    chk_rd(4'h1, {16'h0, `MFLS_OFF_RST});
    chk_rd(4'h2, {16'h0, `MFLS_HOLD_RST});
    chk_rd(4'h3, {16'h0, `MFLS_LEAD_RST});
    chk_rd(4'h4, {16'h0, `MFLS_LEN_RST});
    chk_rd(4'h7, 32'h0);
    wrt(4'h6, 32'hFFFF);
    chk_rd(4'h6, 32'h0);
    be <= 4'h1;
    wrt(4'h2, 32'h0000AB07);
    be <= 4'hF;
    chk_rd(4'h2, 32'h7);
    wrt(4'h2, 32'h5);
    $display("test registers done");
    wrt(4'h1, 32'h6);
    pulse(4);
    chk_q(1'b1);
    chk_rd(4'h5, 32'hD);
    wait_q(1'b0);
    chk_rd(4'h6, 32'h6);
    chk_rd(4'h5, 32'h0);
    $display("test off delay done");
    pulse(60);
    chk_rd(4'h5, 32'h9);
    repeat (100) @(posedge clk_sys_i);
    chk_q(1'b1);
    pulse(4);
    chk_q(1'b0);
    chk_rd(4'h5, 32'h0);
    $display("test permanent light done");
    pulse(4);
    repeat (16) @(posedge clk_sys_i);
    pulse(4);
    chk_q(1'b0);
    chk_rd(4'h5, 32'h0);
    $display("test retrigger done");
    pulse(4);
    repeat (16) @(posedge clk_sys_i);
    clr <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    clr <= 1'b0;
    chk_q(1'b0);
    chk_rd(4'h6, 32'h0);
    $display("test clear done");
    // live lead 4 and length 2 differ from the constants, so the source shows
    wrt(4'h1, 32'hA);
    l_lead <= 16'h0004;
    l_len  <= 16'h0002;
    wrt(4'h0, 32'hC1);
    pulse(4);
    wait_q(1'b0);
    chk_rd(4'h6, 32'h6);
    wait_q(1'b1);
    chk_rd(4'h6, 32'h8);
    wait_q(1'b0);
    chk_rd(4'h6, 32'hA);
    $display("test pre-warning done");
    l_off  <= 16'h0003;
    l_hold <= 16'h0002;
    wrt(4'h0, 32'h30);
    pulse(28);
    chk_rd(4'h5, 32'h9);
    pulse(4);
    pulse(4);
    wait_q(1'b0);
    chk_rd(4'h6, 32'h3);
    $display("test live values done");
    wrt(4'h0, 32'h0);
    pulse(60);
    power();
    chk_q(1'b0);
    chk_rd(4'h5, 32'h0);
    wrt(4'h0, 32'h2);
    pulse(60);
    power();
    chk_q(1'b1);
    chk_rd(4'h5, 32'h9);
    pulse(4);
    $display("test retention done");
    final_report();
  end
endmodule
